// file: hsp_defines.svh
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// Contract
// RULE1 - Input stream has a FIFO whose depth in words is a parameter.
// RULE2 - Ready latency sets cycles from ready low to refusal of new words.
// RULE3 - The data bus is split into symbols of parameter width.
// RULE4 - An option puts the first symbol in the high-order bits.
// RULE5 - Packet mode carries start and end of packet flags; else absent.
// RULE6 - Empty option carries the unused symbol count; else it is omitted.
// RULE7 - An option decides whether the input valid signal exists.
// RULE8 - An option decides whether the output ready signal exists.
// RULE9 - No channel and no error signals are implemented.
// RULE10 - Non-blocking input returns at once, success only if a word was there.
// RULE11 - Non-blocking output completes at once, success only if sink was ready.
// RULE12 - Blocking input stalls the caller until a valid word is taken.
// RULE13 - Blocking output stalls the caller until the sink accepts the word.
// RULE14 - In packet mode input access returns the word's packet flags.
// RULE15 - In packet mode output drives packet flags and empty with the word.
// RULE16 - One invocation may read many words from one stream over many cycles.
// RULE17 - Accesses to different streams have no fixed relative order.
// RULE18 - Caller holds start and arguments while busy; done held during stall.
// RULE19 - Missing valid means always valid; missing ready means always accepted.

`define HSP_ADDR_W          8
`define HSP_EMPTY_W         8

`define HSP_OFF_CTRL        8'h00
`define HSP_OFF_STATUS      8'h04
`define HSP_OFF_IN_SIDE     8'h08
`define HSP_OFF_OUT_SIDE    8'h0C
`define HSP_OFF_IN_BLK      8'h10
`define HSP_OFF_IN_TRY      8'h14
`define HSP_OFF_OUT_BLK     8'h18
`define HSP_OFF_OUT_TRY     8'h1C
`define HSP_OFF_COUNT       8'h20

`define HSP_CTRL_IN_EN      0
`define HSP_CTRL_FLUSH      1
`define HSP_CTRL_RESET      2'h1

`define HSP_STAT_IN_OK      0
`define HSP_STAT_OUT_OK     1
`define HSP_STAT_OUT_BUSY   2
`define HSP_STAT_IN_AVAIL   3
`define HSP_STAT_OVERFLOW   4
`define HSP_STAT_LEVEL_LSB  8

`define HSP_SIDE_SOP        0
`define HSP_SIDE_EOP        1
`define HSP_SIDE_EMPTY_LSB  8

`define HSP_CNT_OUT_LSB     16

`endif

// file: hsp_pkg.sv
`default_nettype none
`include "hsp_defines.svh"

package hsp_pkg;

	typedef struct packed {
		logic                     sop;
		logic                     eop;
		logic [`HSP_EMPTY_W-1:0]  empty;
	} hsp_side_t;

	typedef enum logic [3:0] {
		HSP_REG_NONE     = 4'h0,
		HSP_REG_CTRL     = 4'h1,
		HSP_REG_STATUS   = 4'h2,
		HSP_REG_IN_SIDE  = 4'h3,
		HSP_REG_OUT_SIDE = 4'h4,
		HSP_REG_IN_BLK   = 4'h5,
		HSP_REG_IN_TRY   = 4'h6,
		HSP_REG_OUT_BLK  = 4'h7,
		HSP_REG_OUT_TRY  = 4'h8,
		HSP_REG_COUNT    = 4'h9
	} hsp_reg_t;

	typedef enum logic [1:0] {
		HSP_OUT_IDLE = 2'b00,
		HSP_OUT_HOLD = 2'b01
	} hsp_out_state_t;

endpackage

`default_nettype wire

// file: hsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module hsp_fifo
	import hsp_pkg::*;
#(
	parameter int WIDTH = 42,
	parameter int DEPTH = 8,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] rdata,
	output logic      [CW-1:0]    level,
	output logic                  full,
	output logic                  empty
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign full  = (level == CW'(DEPTH));
	assign empty = (level == '0);
	assign rdata = mem[rd_ptr];

	always_ff @(posedge pclk) begin
		if (push && !full) begin
			mem[wr_ptr] <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push && !full) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop && !empty) begin
				rd_ptr <= bump(rd_ptr);
			end
			level <= CW'(level + (push && !full) - (pop && !empty));
		end
	end

endmodule

`default_nettype wire

// file: hsp_ready_delay.sv
`timescale 1ns/1ps
`default_nettype none

module hsp_ready_delay #(
	parameter int LATENCY = 0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ready_now,
	output logic      ready_late
);

	generate
		if (LATENCY == 0) begin : g_zero
			assign ready_late = ready_now;
		end else begin : g_pipe
			logic [LATENCY-1:0] hist;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hist <= '0;
				end else begin
					// The cast drops the oldest bit, so a latency of one works too.
					hist <= LATENCY'({hist, ready_now});
				end
			end
			assign ready_late = hist[LATENCY-1];
		end
	endgenerate

endmodule

`default_nettype wire

// file: hsp_stream_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.svh"

module hsp_stream_port
	import hsp_pkg::*;
#(
	parameter int DATA_W                     = 32,
	parameter int symbol_width               = 8,
	parameter int FIFO_DEPTH                 = 8,
	parameter int READY_LATENCY              = 0,
	parameter bit msb_first_symbol_order     = 1'b0,
	parameter bit packet_mode_enable         = 1'b1,
	parameter bit unused_symbol_count_enable = 1'b1,
	parameter bit source_qualifier_enable    = 1'b1,
	parameter bit sink_backpressure_enable   = 1'b1
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`HSP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [DATA_W-1:0]      in_data,
	input  wire logic                   in_valid,
	input  wire hsp_side_t              in_side,
	output logic                        in_ready,
	output logic      [DATA_W-1:0]      out_data,
	output logic                        out_valid,
	output hsp_side_t                   out_side,
	input  wire logic                   out_ready
);

	// The stream carries only data, valid, ready and packet sideband. [RULE9]

	localparam int SYMS = DATA_W / symbol_width;
	localparam int SW   = $bits(hsp_side_t);
	localparam int FW   = DATA_W + SW;
	localparam int CW   = $clog2(FIFO_DEPTH + 1);
	localparam logic [CW-1:0] IN_ROOM = CW'(FIFO_DEPTH - 1 - READY_LATENCY);

	hsp_reg_t         sel;
	logic             setup;
	logic             access;
	logic [1:0]       ctrl;
	logic             flush;
	hsp_side_t        out_side_cfg;
	hsp_side_t        in_side_last;
	logic             in_ok;
	logic             out_ok;
	logic             overflow;
	logic [15:0]      in_words;
	logic [15:0]      out_words;
	logic             in_ready_late;
	logic             in_take;
	logic             in_push;
	logic [FW-1:0]    fifo_wdata;
	logic [FW-1:0]    fifo_rdata;
	logic [CW-1:0]    fifo_level;
	logic             fifo_full;
	logic             fifo_empty;
	logic             in_avail;
	logic             in_pop;
	logic             out_allowed;
	logic             out_ready_late;
	logic             out_fire;
	logic             out_is_try;
	hsp_out_state_t   out_state;
	hsp_out_state_t   next_out_state;
	logic             out_start;
	logic [DATA_W-1:0] head_data;
	hsp_side_t        head_side;

	// Symbol reordering is its own inverse, so one function serves both ways.
	function automatic logic [DATA_W-1:0] sym_order(
		input logic [DATA_W-1:0] w
	);
		logic [DATA_W-1:0] r;
		r = w;
		if (msb_first_symbol_order) begin // [RULE4]
			for (int i = 0; i < SYMS; i++) begin // [RULE3]
				r[i*symbol_width +: symbol_width] =
					w[(SYMS-1-i)*symbol_width +: symbol_width];
			end
		end
		return r;
	endfunction

	// Drops whichever sideband fields the configuration leaves out.
	function automatic hsp_side_t side_mask(input hsp_side_t s);
		hsp_side_t r;
		r = '0;
		if (packet_mode_enable) begin // [RULE5]
			r.sop = s.sop;
			r.eop = s.eop;
			if (unused_symbol_count_enable) begin // [RULE6]
				r.empty = s.empty;
			end
		end
		return r;
	endfunction

	assign setup  = psel && !penable;
	assign access = psel && penable;

	always_comb begin
		case (paddr)
			`HSP_OFF_CTRL:     sel = HSP_REG_CTRL;
			`HSP_OFF_STATUS:   sel = HSP_REG_STATUS;
			`HSP_OFF_IN_SIDE:  sel = HSP_REG_IN_SIDE;
			`HSP_OFF_OUT_SIDE: sel = HSP_REG_OUT_SIDE;
			`HSP_OFF_IN_BLK:   sel = HSP_REG_IN_BLK;
			`HSP_OFF_IN_TRY:   sel = HSP_REG_IN_TRY;
			`HSP_OFF_OUT_BLK:  sel = HSP_REG_OUT_BLK;
			`HSP_OFF_OUT_TRY:  sel = HSP_REG_OUT_TRY;
			`HSP_OFF_COUNT:    sel = HSP_REG_COUNT;
			default:           sel = HSP_REG_NONE;
		endcase
	end

	// Input side.

	// Ready leaves room for every word the source may still send during
	// the latency window, so a well-behaved source never overflows. [RULE2]
	assign in_ready = ctrl[`HSP_CTRL_IN_EN] && !flush &&
		(fifo_level <= IN_ROOM);

	hsp_ready_delay #(
		.LATENCY (READY_LATENCY)
	) u_in_delay (
		.pclk       (pclk),
		.presetn    (presetn),
		.ready_now  (in_ready),
		.ready_late (in_ready_late)
	);

	// Without a valid pin every cycle in the ready window is a word. [RULE7]
	assign in_take = in_ready_late &&
		(source_qualifier_enable ? in_valid : 1'b1); // [RULE19]
	assign in_push    = in_take && !fifo_full;
	assign fifo_wdata = {side_mask(in_side), in_data}; // [RULE14]

	hsp_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH),
		.CW    (CW)
	) u_in_fifo ( // [RULE1]
		.pclk    (pclk),
		.presetn (presetn),
		.flush   (flush),
		.push    (in_push),
		.wdata   (fifo_wdata),
		.pop     (in_pop),
		.rdata   (fifo_rdata),
		.level   (fifo_level),
		.full    (fifo_full),
		.empty   (fifo_empty)
	);

	assign head_data = fifo_rdata[DATA_W-1:0];
	assign head_side = fifo_rdata[FW-1:DATA_W];
	assign in_avail  = !fifo_empty;

	// Each read of a blocking or trying address pops at most one word, so
	// a caller may pull many words from the stream in sequence. [RULE16]
	assign in_pop = access && !pwrite && in_avail &&
		(sel == HSP_REG_IN_BLK || sel == HSP_REG_IN_TRY);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ok        <= 1'b0;
			in_side_last <= '0;
		end else if (access && !pwrite && sel == HSP_REG_IN_TRY) begin
			in_ok <= in_avail; // [RULE10]
			if (in_avail) begin
				in_side_last <= head_side; // [RULE14]
			end
		end else if (in_pop) begin
			in_ok        <= 1'b1; // [RULE12]
			in_side_last <= head_side;
		end
	end

	// Output side.

	hsp_ready_delay #(
		.LATENCY (READY_LATENCY)
	) u_out_delay (
		.pclk       (pclk),
		.presetn    (presetn),
		.ready_now  (out_ready),
		.ready_late (out_ready_late)
	);

	// Valid is only raised where the sink's ready permits a transfer, so a
	// raised valid is always an accepted word. [RULE2]
	assign out_allowed = sink_backpressure_enable ?
		out_ready_late : 1'b1; // [RULE8] [RULE19]
	assign out_fire    = (out_state == HSP_OUT_HOLD) && out_allowed;
	assign out_valid   = out_fire;
	assign out_start   = setup && pwrite &&
		(sel == HSP_REG_OUT_BLK || sel == HSP_REG_OUT_TRY);

	always_comb begin
		next_out_state = out_state;
		case (out_state)
			HSP_OUT_IDLE: begin
				if (out_start) begin
					next_out_state = HSP_OUT_HOLD;
				end
			end
			HSP_OUT_HOLD: begin
				if (out_fire || (access && out_is_try)) begin
					next_out_state = HSP_OUT_IDLE;
				end
			end
			default: next_out_state = HSP_OUT_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_state <= HSP_OUT_IDLE;
		end else begin
			out_state <= next_out_state;
		end
	end

	// Word and sideband are latched together in the setup cycle. [RULE15]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_data   <= '0;
			out_side   <= '0;
			out_is_try <= 1'b0;
		end else if (out_start && out_state == HSP_OUT_IDLE) begin
			out_data   <= sym_order(pwdata[DATA_W-1:0]);
			out_side   <= side_mask(out_side_cfg); // [RULE15]
			out_is_try <= (sel == HSP_REG_OUT_TRY);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ok <= 1'b0;
		end else if (access && pwrite && out_state == HSP_OUT_HOLD) begin
			if (out_is_try) begin
				out_ok <= out_allowed; // [RULE11]
			end else if (out_fire) begin
				out_ok <= 1'b1; // [RULE13]
			end
		end
	end

	// Registers.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl         <= `HSP_CTRL_RESET;
			out_side_cfg <= '0;
		end else if (access && pwrite) begin
			if (sel == HSP_REG_CTRL) begin
				ctrl <= pwdata[1:0];
			end else begin
				ctrl[`HSP_CTRL_FLUSH] <= 1'b0;
			end
			if (sel == HSP_REG_OUT_SIDE) begin
				out_side_cfg.sop   <= pwdata[`HSP_SIDE_SOP];
				out_side_cfg.eop   <= pwdata[`HSP_SIDE_EOP];
				out_side_cfg.empty <=
					pwdata[`HSP_SIDE_EMPTY_LSB +: `HSP_EMPTY_W];
			end
		end else begin
			ctrl[`HSP_CTRL_FLUSH] <= 1'b0;
		end
	end

	// Flush is a one-cycle effect of writing the flush bit.
	assign flush = ctrl[`HSP_CTRL_FLUSH];

	// A word arriving while the clear is written still sets the flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow <= 1'b0;
		end else if (in_take && fifo_full) begin
			overflow <= 1'b1;
		end else if (access && pwrite && sel == HSP_REG_STATUS &&
				pwdata[`HSP_STAT_OVERFLOW]) begin
			overflow <= 1'b0;
		end
	end

	// Both streams count independently; neither waits for the other. [RULE17]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_words  <= '0;
			out_words <= '0;
		end else begin
			if (access && pwrite && sel == HSP_REG_COUNT) begin
				in_words  <= 16'(in_push);
				out_words <= 16'(out_fire);
			end else begin
				in_words  <= 16'(in_words + in_push);
				out_words <= 16'(out_words + out_fire);
			end
		end
	end

	// Blocking addresses hold the bus in its access phase until the word
	// moves; this is the caller's stall. [RULE12] [RULE13]
	always_comb begin
		pready = 1'b1;
		if (access) begin
			if (sel == HSP_REG_IN_BLK && !pwrite) begin
				pready = in_avail;
			end else if (sel == HSP_REG_OUT_BLK && pwrite) begin
				pready = out_fire;
			end
		end
	end

	assign pslverr = access && (sel == HSP_REG_NONE);

	always_comb begin
		prdata = '0;
		case (sel)
			HSP_REG_CTRL: begin
				prdata[`HSP_CTRL_IN_EN] = ctrl[`HSP_CTRL_IN_EN];
			end
			HSP_REG_STATUS: begin
				prdata[`HSP_STAT_IN_OK]    = in_ok;
				prdata[`HSP_STAT_OUT_OK]   = out_ok;
				prdata[`HSP_STAT_OUT_BUSY] = (out_state == HSP_OUT_HOLD);
				prdata[`HSP_STAT_IN_AVAIL] = in_avail;
				prdata[`HSP_STAT_OVERFLOW] = overflow;
				prdata[`HSP_STAT_LEVEL_LSB +: CW] = fifo_level;
			end
			HSP_REG_IN_SIDE: begin
				prdata[`HSP_SIDE_SOP] = in_side_last.sop;
				prdata[`HSP_SIDE_EOP] = in_side_last.eop;
				prdata[`HSP_SIDE_EMPTY_LSB +: `HSP_EMPTY_W] =
					in_side_last.empty;
			end
			HSP_REG_OUT_SIDE: begin
				prdata[`HSP_SIDE_SOP] = out_side_cfg.sop;
				prdata[`HSP_SIDE_EOP] = out_side_cfg.eop;
				prdata[`HSP_SIDE_EMPTY_LSB +: `HSP_EMPTY_W] =
					out_side_cfg.empty;
			end
			HSP_REG_IN_BLK, HSP_REG_IN_TRY: begin
				if (in_avail) begin
					prdata[DATA_W-1:0] = sym_order(head_data);
				end
			end
			HSP_REG_COUNT: begin
				prdata[15:0] = in_words;
				prdata[`HSP_CNT_OUT_LSB +: 16] = out_words;
			end
			default: prdata = '0;
		endcase
	end

endmodule

`default_nettype wire

// file: hsp_stream_port_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.svh"

module hsp_stream_port_props
	import hsp_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`HSP_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pready,
	input wire logic                   in_valid,
	input wire logic                   in_ready,
	input wire logic [DATA_W-1:0]      out_data,
	input wire logic                   out_valid,
	input wire hsp_side_t              out_side,
	input wire logic                   out_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_word_in;
		in_valid && in_ready;
	endsequence
	sequence s_blk_rd;
		psel && penable && !pwrite && paddr == `HSP_OFF_IN_BLK;
	endsequence
	sequence s_blk_wr;
		psel && penable && pwrite && paddr == `HSP_OFF_OUT_BLK;
	endsequence

	AST_IN_TO_BLK: assert property (s_word_in ##1 s_blk_rd |-> pready)
		else $error("blocking read stalled with a word stored");
	AST_BLK_STALL: assert property (s_blk_wr ##0 !out_ready
		|-> !pready)
		else $error("blocking write ended without sink ready");
	AST_BLK_DONE: assert property (s_blk_wr ##0 out_ready
		|-> out_valid)
		else $error("blocking write missed a ready sink");
	AST_TRY_OUT: assert property (psel && penable && pwrite
		&& paddr == `HSP_OFF_OUT_TRY |-> pready && out_valid == out_ready)
		else $error("non-blocking write did not finish at once");
	AST_TRY_IN: assert property (psel && penable && !pwrite
		&& paddr == `HSP_OFF_IN_TRY |-> pready)
		else $error("non-blocking read waited");
	AST_VALID_CAUSE: assert property (out_valid |-> psel && penable
		&& pwrite && out_ready)
		else $error("output word sent without a write or ready sink");
	AST_OUT_WORD: assert property (out_valid |-> out_data == pwdata)
		else $error("output word differs from written data");
	AST_OUT_HOLD: assert property (out_valid |=> $stable(out_data)
		&& $stable(out_side))
		else $error("output word or sideband changed after transfer");
endmodule

bind hsp_stream_port hsp_stream_port_props #(.DATA_W(DATA_W)) u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.in_valid, .in_ready, .out_data, .out_valid, .out_side, .out_ready
);

`default_nettype wire

// file: hsp_stream_partner.sv
`timescale 1ns/1ps
`default_nettype none

module hsp_stream_partner
	import hsp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [1:0]  ready_mode,
	input  wire logic        in_ready,
	output logic      [31:0] in_data,
	output logic             in_valid,
	output hsp_side_t        in_side,
	input  wire logic [31:0] out_data,
	input  wire logic        out_valid,
	input  wire hsp_side_t   out_side,
	output logic             out_ready,
	output logic      [31:0] got_data,
	output hsp_side_t        got_side,
	output logic      [7:0]  got_n
);
	logic [1:0] slow_cnt;

	initial begin
		in_data = 32'h0;
		in_valid = 1'b0;
		in_side = '0;
	end

	// The word is held until the port takes it; the idle lines are scrambled
	// so a port that samples them without valid sees garbage.
	task automatic send(input logic [31:0] d, input hsp_side_t s,
			output logic ok);
		int i;
		ok = 1'b0;
		// An edge passes first, so back-to-back sends never drive valid twice
		// in one time step.
		@(posedge pclk);
		in_data <= d;
		in_side <= s;
		in_valid <= 1'b1;
		for (i = 0; i < 200 && !ok; i++) begin
			@(posedge pclk);
			ok = in_ready;
		end
		in_valid <= 1'b0;
		in_data <= ~d;
		in_side <= ~s;
	endtask

	// Mode 2 answers one cycle in four, which exercises the stall path.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cnt <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			slow_cnt <= slow_cnt + 2'h1;
			out_ready <= ready_mode == 2'h1 ||
				(ready_mode == 2'h2 && slow_cnt == 2'h3);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			got_data <= 32'h0;
			got_side <= '0;
			got_n <= 8'h0;
		end else if (out_valid) begin
			got_data <= out_data;
			got_side <= out_side;
			got_n <= got_n + 8'h1;
		end
	end
endmodule

`default_nettype wire

// file: hsp_stream_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.svh"

module hsp_stream_port_test
	import hsp_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] in_data;
	logic        in_valid;
	hsp_side_t   in_side;
	logic        in_ready;
	logic [31:0] out_data;
	logic        out_valid;
	hsp_side_t   out_side;
	logic        out_ready;
	logic [1:0]  ready_mode = 2'h0;
	logic [31:0] got_data;
	hsp_side_t   got_side;
	logic [7:0]  got_n;
	logic [31:0] rd;
	logic        err;
	logic        ok;
	logic [7:0]  n0;
	int          errors = 0;
	int          n_checks = 0;

	always #50 pclk = ~pclk;

	hsp_stream_port dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .in_data, .in_valid, .in_side, .in_ready,
		.out_data, .out_valid, .out_side, .out_ready
	);

	hsp_stream_partner peer (
		.pclk, .presetn, .ready_mode, .in_ready, .in_data, .in_valid, .in_side,
		.out_data, .out_valid, .out_side, .out_ready, .got_data, .got_side,
		.got_n
	);

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 300; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 300) begin
			errors++;
			stop_test();
		end
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
			input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, err);
		chk(nm, rd, exp);
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl", `HSP_OFF_CTRL, 32'h1);
		rdc("status", `HSP_OFF_STATUS, 32'h0);
		apb(1'b0, 8'h24, 32'h0, rd, err);
		chk("unmapped", {31'h0, err}, 32'h1);
		rdc("try empty", `HSP_OFF_IN_TRY, 32'h0);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("in_ok empty", {31'h0, rd[0]}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			peer.send(32'hA500_0000 + i, hsp_side_t'{i == 0, i == 2,
				(i == 2) ? 8'h02 : 8'h00}, ok);
			chk("send", {31'h0, ok}, 32'h1);
		end
		rdc("try word", `HSP_OFF_IN_TRY, 32'hA500_0000);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("in_ok word", {31'h0, rd[0]}, 32'h1);
		rdc("side first", `HSP_OFF_IN_SIDE, 32'h1);
		rdc("blk one", `HSP_OFF_IN_BLK, 32'hA500_0001);
		rdc("blk two", `HSP_OFF_IN_BLK, 32'hA500_0002);
		rdc("side last", `HSP_OFF_IN_SIDE, 32'h0000_0202);
		fork
			rdc("blk wait", `HSP_OFF_IN_BLK, 32'h5A5A_0001);
			begin
				repeat (6) @(posedge pclk);
				peer.send(32'h5A5A_0001, '0, ok);
				chk("late send", {31'h0, ok}, 32'h1);
			end
		join
		for (int i = 0; i < 8; i++) begin
			peer.send(32'hC000_0000 + i, '0, ok);
			chk("fill", {31'h0, ok}, 32'h1);
		end
		@(posedge pclk);
		chk("ready full", {31'h0, in_ready}, 32'h0);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("level full", {28'h0, rd[11:8]}, 32'h8);
		apb(1'b1, `HSP_OFF_CTRL, 32'h3, rd, err);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("level flushed", {28'h0, rd[11:8]}, 32'h0);
		ready_mode <= 2'h1;
		apb(1'b1, `HSP_OFF_OUT_SIDE, 32'h0000_0303, rd, err);
		apb(1'b1, `HSP_OFF_OUT_TRY, 32'h1234_5678, rd, err);
		@(posedge pclk);
		chk("try out", got_data, 32'h1234_5678);
		chk("side out", {22'h0, got_side}, 32'h0000_0303);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("out_ok", {31'h0, rd[1]}, 32'h1);
		ready_mode <= 2'h0;
		repeat (2) @(posedge pclk);
		n0 = got_n;
		apb(1'b1, `HSP_OFF_OUT_TRY, 32'h0BAD_0BAD, rd, err);
		apb(1'b0, `HSP_OFF_STATUS, 32'h0, rd, err);
		chk("out_ok refused", {31'h0, rd[1]}, 32'h0);
		chk("nothing sent", {24'h0, got_n}, {24'h0, n0});
		ready_mode <= 2'h2;
		apb(1'b1, `HSP_OFF_OUT_BLK, 32'hCAFE_0001, rd, err);
		@(posedge pclk);
		chk("blk out", got_data, 32'hCAFE_0001);
		chk("blk count", {24'h0, got_n}, {24'h0, n0 + 8'h1});
		rdc("count", `HSP_OFF_COUNT, 32'h0002_000C);
		apb(1'b1, `HSP_OFF_COUNT, 32'h0, rd, err);
		rdc("count clear", `HSP_OFF_COUNT, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
